// *** shared/rsec_defs.svh ***
// Offsets, field positions, reset values and counts of the state-exit block
`ifndef RSEC_DEFS_SVH
`define RSEC_DEFS_SVH

// Register indices and their Wishbone byte addresses (index times four)
`define RSEC_CFG_INDEX 16'hDF13
`define RSEC_CFG_ADDR 32'h0003_7C4C
`define RSEC_TMO_INDEX 16'hDF30
`define RSEC_TMO_ADDR 32'h0003_7CC0
`define RSEC_STAT_INDEX 16'hDF31
`define RSEC_STAT_ADDR 32'h0003_7CC4

// State-exit configuration fields
`define RSEC_CLR_MSB 5
`define RSEC_CLR_LSB 4
`define RSEC_RXOFF_MSB 3
`define RSEC_RXOFF_LSB 2
`define RSEC_TXOFF_MSB 1
`define RSEC_TXOFF_LSB 0
`define RSEC_CLR_RST 2'h3
`define RSEC_RXOFF_RST 2'h0
`define RSEC_TXOFF_RST 2'h0

// Receive-timeout configuration fields
`define RSEC_RXT_MSB 2
`define RSEC_RXT_LSB 0
`define RSEC_QUAL_BIT 3
`define RSEC_RES_MSB 5
`define RSEC_RES_LSB 4
`define RSEC_RXT_RST 3'h7
`define RSEC_QUAL_RST 1'h0
`define RSEC_RES_RST 2'h0
`define RSEC_RXT_OFF 3'h7

// Timeout scale per wake resolution, relative to the lowest column
`define RSEC_MULT_RES0 4'h1
`define RSEC_MULT_RES1 4'h5
`define RSEC_MULT_RES2 4'h9
`define RSEC_MULT_RES3 4'hD

// Cycles of the longest timeout in the lowest resolution column
`define RSEC_TMO_UNIT_CYC 1024

`endif

// *** shared/rsec_pkg.sv ***
// Types shared by the state-exit control block
package rsec_pkg;

    // Radio main states driven by the exit logic
    typedef enum logic [1:0] {
        RSEC_ST_IDLE,
        RSEC_ST_RX,
        RSEC_ST_TX,
        RSEC_ST_SYNTH_ON_TX_READY
    } rsec_state_e;

    // State-exit configuration fields
    typedef struct packed {
        logic [1:0] clear_channel_mode;
        logic [1:0] after_receive_next_state;
        logic [1:0] after_transmit_next_state;
    } rsec_cfg_s;

    // Receive-timeout configuration fields
    typedef struct packed {
        logic [1:0] wake_timer_resolution;
        logic timeout_qualifier_select;
        logic [2:0] rx_timeout_setting;
    } rsec_tmo_s;

    // Indications from the modem
    typedef struct packed {
        logic rssi_below_thresh;
        logic pkt_receiving;
        logic rx_pkt_done;
        logic tx_pkt_done;
        logic sync_found;
        logic preamble_quality_level;
    } rsec_rf_in_s;

    // Command strobes from the controller
    typedef struct packed {
        logic go_rx;
        logic go_tx;
        logic go_idle;
    } rsec_cmd_s;

endpackage

// *** hdl/rsec_timeout.sv ***
// Sync-search timer of the receive state
`timescale 1ns/1ps
`include "rsec_defs.svh"

module rsec_timeout import rsec_pkg::*; #(
    parameter int unsigned UNIT_CYC = `RSEC_TMO_UNIT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,          // Start a new search
    input wire logic run,           // Radio is in receive
    input wire rsec_tmo_s tmo,      // Timeout configuration
    output logic expired_o          // One-cycle expiry pulse
);

    logic [31:0] cnt_q;             // Cycles left
    logic [31:0] expect_cyc;        // Reload value
    logic [3:0] mult;               // Column scale
    logic disabled;                 // Top setting, no timeout

    ////////////////////////////////////////////////////////////////////////
    // Reload value: halves per setting step
    always_comb begin
        case (tmo.wake_timer_resolution)
            2'h0: mult = `RSEC_MULT_RES0;
            2'h1: mult = `RSEC_MULT_RES1;
            2'h2: mult = `RSEC_MULT_RES2;
            default: mult = `RSEC_MULT_RES3;
        endcase
        disabled = (tmo.rx_timeout_setting == `RSEC_RXT_OFF);
        expect_cyc = (32'(UNIT_CYC) * {28'h0, mult})
            >> tmo.rx_timeout_setting;
    end

    ////////////////////////////////////////////////////////////////////////
    // Down counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h0;
        end else if (load) begin
            cnt_q <= disabled ? 32'h0 : expect_cyc;
        end else if (run && cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
        end
    end

    // Expiry pulse, never while disabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            expired_o <= 1'b0;
        end else begin
            expired_o <= run && !load && !disabled
                && cnt_q == 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_timeout_reload: assert property (@(posedge clk) disable iff (rst)
        (load && !disabled) |=> cnt_q == $past(expect_cyc))
        else $error("timer reload does not match setting");
    a_timeout_off: assert property (@(posedge clk) disable iff (rst)
        (tmo.rx_timeout_setting == `RSEC_RXT_OFF) |=> !expired_o)
        else $error("timer expired while disabled");

endmodule

// *** hdl/rsec_top.sv ***
// State-exit configuration, clear-channel flag and radio next-state logic
`timescale 1ns/1ps
`include "rsec_defs.svh"

module rsec_top import rsec_pkg::*; #(
    parameter int unsigned TMO_UNIT_CYC = `RSEC_TMO_UNIT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire rsec_rf_in_s rf_in,
    input wire rsec_cmd_s cmd,
    output logic channel_clear_flag,
    output rsec_state_e radio_state,
    output logic preamble_restart,
    output logic rx_timeout_exit
);

    rsec_cfg_s cfg_q;               // State-exit configuration
    rsec_tmo_s tmo_q;               // Receive-timeout configuration
    rsec_state_e state_q;           // Current radio state
    rsec_state_e state_d;           // Next radio state
    logic req;                      // New bus request this cycle
    logic wr_en;                    // Write takes effect
    logic [31:0] rd_d;              // Read data for this address
    logic tmo_load;                 // Start sync search
    logic tmo_expired;              // Timer pulse
    logic qualified;                // Stay in receive on expiry
    logic restart_d;                // Preamble restart this cycle
    logic exit_d;                   // Timeout exit this cycle

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one-wait answer, unmapped reads give zero
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Write lands on the edge where the master sees ack, not earlier
    assign wr_en = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
        && wb_sel_i[0];

    // Read multiplexer
    always_comb begin
        rd_d = 32'h0;
        case (wb_adr_i)
            `RSEC_CFG_ADDR: rd_d = {26'h0, cfg_q};
            `RSEC_TMO_ADDR: rd_d = {26'h0, tmo_q};
            `RSEC_STAT_ADDR: rd_d = {29'h0, channel_clear_flag, state_q};
            default: rd_d = 32'h0;
        endcase
    end

    // Acknowledge and read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= (req && !wb_we_i) ? rd_d : 32'h0;
        end
    end

    // Configuration registers, upper bits are never stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q.clear_channel_mode <= `RSEC_CLR_RST;
            cfg_q.after_receive_next_state <= `RSEC_RXOFF_RST;
            cfg_q.after_transmit_next_state <= `RSEC_TXOFF_RST;
            tmo_q.rx_timeout_setting <= `RSEC_RXT_RST;
            tmo_q.timeout_qualifier_select <= `RSEC_QUAL_RST;
            tmo_q.wake_timer_resolution <= `RSEC_RES_RST;
        end else if (wr_en && wb_adr_i == `RSEC_CFG_ADDR) begin
            cfg_q.clear_channel_mode <=
                wb_dat_i[`RSEC_CLR_MSB:`RSEC_CLR_LSB];
            cfg_q.after_receive_next_state <=
                wb_dat_i[`RSEC_RXOFF_MSB:`RSEC_RXOFF_LSB];
            cfg_q.after_transmit_next_state <=
                wb_dat_i[`RSEC_TXOFF_MSB:`RSEC_TXOFF_LSB];
        end else if (wr_en && wb_adr_i == `RSEC_TMO_ADDR) begin
            tmo_q.rx_timeout_setting <= wb_dat_i[`RSEC_RXT_MSB:`RSEC_RXT_LSB];
            tmo_q.timeout_qualifier_select <= wb_dat_i[`RSEC_QUAL_BIT];
            tmo_q.wake_timer_resolution <=
                wb_dat_i[`RSEC_RES_MSB:`RSEC_RES_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clear-channel indication per selected mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            channel_clear_flag <= 1'b0;
        end else begin
            case (cfg_q.clear_channel_mode)
                2'h0: channel_clear_flag <= 1'b1;
                2'h1: channel_clear_flag <= rf_in.rssi_below_thresh;
                2'h2: channel_clear_flag <= !rf_in.pkt_receiving;
                default: channel_clear_flag <= rf_in.rssi_below_thresh
                    && !rf_in.pkt_receiving;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next radio state; idle command wins, then packet end, then timer
    assign qualified = rf_in.sync_found || (tmo_q.timeout_qualifier_select
        && rf_in.preamble_quality_level);

    always_comb begin
        state_d = state_q;
        restart_d = 1'b0;
        exit_d = 1'b0;
        case (state_q)
            RSEC_ST_RX: begin
                if (cmd.go_idle) begin
                    state_d = RSEC_ST_IDLE;
                end else if (rf_in.rx_pkt_done) begin
                    case (cfg_q.after_receive_next_state)
                        2'h0: state_d = RSEC_ST_IDLE;
                        2'h1: state_d = RSEC_ST_SYNTH_ON_TX_READY;
                        2'h2: state_d = RSEC_ST_TX;
                        default: state_d = RSEC_ST_RX;
                    endcase
                end else if (tmo_expired && !qualified) begin
                    state_d = RSEC_ST_IDLE;
                    exit_d = 1'b1;
                end
            end
            RSEC_ST_TX: begin
                if (cmd.go_idle) begin
                    state_d = RSEC_ST_IDLE;
                end else if (rf_in.tx_pkt_done) begin
                    case (cfg_q.after_transmit_next_state)
                        2'h0: state_d = RSEC_ST_IDLE;
                        2'h1: state_d = RSEC_ST_SYNTH_ON_TX_READY;
                        2'h2: begin
                            state_d = RSEC_ST_TX;
                            restart_d = 1'b1;
                        end
                        default: state_d = RSEC_ST_RX;
                    endcase
                end
            end
            default: begin
                // Idle or synthesizer on: wait for a command
                if (cmd.go_idle) begin
                    state_d = RSEC_ST_IDLE;
                end else if (cmd.go_rx) begin
                    state_d = RSEC_ST_RX;
                end else if (cmd.go_tx) begin
                    state_d = RSEC_ST_TX;
                end
            end
        endcase
    end

    // State and event outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= RSEC_ST_IDLE;
            preamble_restart <= 1'b0;
            rx_timeout_exit <= 1'b0;
        end else begin
            state_q <= state_d;
            preamble_restart <= restart_d;
            rx_timeout_exit <= exit_d;
        end
    end

    assign radio_state = state_q;

    ////////////////////////////////////////////////////////////////////////
    // Sync-search timer, restarted on every entry into receive
    assign tmo_load = (state_d == RSEC_ST_RX) && (state_q != RSEC_ST_RX
        || rf_in.rx_pkt_done);

    rsec_timeout #(
        .UNIT_CYC(TMO_UNIT_CYC)
    ) u_timeout (
        .clk(clk),
        .rst(rst),
        .load(tmo_load),
        .run(state_q == RSEC_ST_RX),
        .tmo(tmo_q),
        .expired_o(tmo_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_clear_always: assert property (
        cfg_q.clear_channel_mode == 2'h0 |=> channel_clear_flag)
        else $error("clear flag low in always mode");
    a_clear_rssi: assert property (
        cfg_q.clear_channel_mode == 2'h1
        |=> channel_clear_flag == $past(rf_in.rssi_below_thresh))
        else $error("clear flag does not follow signal strength");
    a_clear_both: assert property (
        cfg_q.clear_channel_mode == 2'h3 && rf_in.pkt_receiving
        |=> !channel_clear_flag)
        else $error("clear flag high during reception");
    a_rxoff_tx: assert property (
        state_q == RSEC_ST_RX && rf_in.rx_pkt_done && !cmd.go_idle
        && cfg_q.after_receive_next_state == 2'h2
        |=> radio_state == RSEC_ST_TX)
        else $error("wrong state after receive");
    a_rxoff_idle: assert property (
        state_q == RSEC_ST_RX && rf_in.rx_pkt_done && !cmd.go_idle
        && cfg_q.after_receive_next_state == 2'h0
        |=> radio_state == RSEC_ST_IDLE)
        else $error("receive did not return to idle");
    a_txoff_rx: assert property (
        state_q == RSEC_ST_TX && rf_in.tx_pkt_done && !cmd.go_idle
        && cfg_q.after_transmit_next_state == 2'h3
        |=> radio_state == RSEC_ST_RX)
        else $error("wrong state after transmit");
    a_tx_repeat: assert property (
        preamble_restart |-> radio_state == RSEC_ST_TX
        && $past(cfg_q.after_transmit_next_state) == 2'h2)
        else $error("preamble restart outside transmit repeat");
    a_timeout_exit: assert property (
        state_q == RSEC_ST_RX && tmo_expired && !qualified
        && !cmd.go_idle && !rf_in.rx_pkt_done
        |=> radio_state == RSEC_ST_IDLE && rx_timeout_exit)
        else $error("receive not left on timeout");
    a_upper_zero: assert property (
        wb_ack_o |-> wb_dat_o[7:6] == 2'h0)
        else $error("unused bits read non-zero");

    c_tx_repeat: cover property (preamble_restart);
    c_timeout_exit: cover property (rx_timeout_exit);
    c_rx_stay: cover property (state_q == RSEC_ST_RX && rf_in.rx_pkt_done
        ##1 radio_state == RSEC_ST_RX);

endmodule

// *** verif/rsec_testbench.sv ***
// Self-checking bench of the state-exit control block
`timescale 1ns/1ps
`include "rsec_defs.svh"

module testbench import rsec_pkg::*;;

    // Short timer unit keeps timeout runs brief
    localparam int UNIT = 64;
    localparam int WAIT_MAX = 300;

    logic clk;
    logic rst;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [31:0] wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    rsec_rf_in_s rf_in;
    rsec_cmd_s cmd;
    logic channel_clear_flag;
    rsec_state_e radio_state;
    logic preamble_restart;
    logic rx_timeout_exit;
    int bad_count = 0;
    int total_checks = 0;

    rsec_top #(.TMO_UNIT_CYC(UNIT)) i_dut (
        .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rf_in(rf_in), .cmd(cmd), .channel_clear_flag(channel_clear_flag),
        .radio_state(radio_state), .preamble_restart(preamble_restart),
        .rx_timeout_exit(rx_timeout_exit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock of 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare one value and count the result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got,
                     exp);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One classic Wishbone cycle, waits for ack under a bound
    task automatic wb_io(input logic we, input logic [31:0] adr,
                         input logic [7:0] wd, input logic [3:0] sel,
                         output logic [31:0] rd);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, wd};
        wb_sel_i <= sel;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (n >= 50) chk(32'h0, 32'h1, "bus ack missing");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    // Register write with all byte lanes
    task automatic wr(input logic [31:0] adr, input logic [7:0] d);
        logic [31:0] unused;
        wb_io(1'b1, adr, d, 4'hF, unused);
    endtask

    // Register read compared with an expected value
    task automatic rd_chk(input logic [31:0] adr, input logic [31:0] exp,
                          input string what);
        logic [31:0] d;
        wb_io(1'b0, adr, 8'h00, 4'hF, d);
        chk(d, exp, what);
    endtask

    // One-cycle command strobe; returns just after it has been taken
    task automatic pulse_cmd(input logic [2:0] c);
        @(posedge clk);
        cmd <= rsec_cmd_s'(c);
        @(posedge clk);
        cmd <= rsec_cmd_s'(3'h0);
        #1;
    endtask

    // One-cycle modem indication pulse
    task automatic pulse_rf(input logic [5:0] r);
        @(posedge clk);
        rf_in <= rsec_rf_in_s'(r);
        @(posedge clk);
        rf_in <= rsec_rf_in_s'(6'h00);
        #1;
    endtask

    // Enter receive with a timeout setting and held indications
    task automatic run_tmo(input logic [1:0] res, input logic [2:0] set,
                           input logic qual, input logic [5:0] hold,
                           output int n);
        wr(`RSEC_CFG_ADDR, 8'h00);
        wr(`RSEC_TMO_ADDR, {2'b00, res, qual, set});
        @(posedge clk);
        rf_in <= rsec_rf_in_s'(hold);
        pulse_cmd(3'h4);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rx_timeout_exit !== 1'b1 && n < WAIT_MAX);
        rf_in <= rsec_rf_in_s'(6'h00);
        repeat (2) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main test sequence
    initial begin
        automatic rsec_state_e rx_next[4] = '{RSEC_ST_IDLE,
            RSEC_ST_SYNTH_ON_TX_READY, RSEC_ST_TX, RSEC_ST_RX};
        automatic rsec_state_e tx_next[4] = '{RSEC_ST_IDLE,
            RSEC_ST_SYNTH_ON_TX_READY, RSEC_ST_TX, RSEC_ST_RX};
        logic [31:0] d;
        logic exp_flag;
        int n0;
        int n;
        rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 32'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        rf_in = rsec_rf_in_s'(6'h00);
        cmd = rsec_cmd_s'(3'h0);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unused bits, byte lane and unmapped address
        rd_chk(`RSEC_CFG_ADDR, 32'h30, "cfg reset");
        rd_chk(`RSEC_TMO_ADDR, 32'h07, "tmo reset");
        wr(`RSEC_CFG_ADDR, 8'hFF);
        rd_chk(`RSEC_CFG_ADDR, 32'h3F, "cfg upper bits");
        wb_io(1'b1, `RSEC_CFG_ADDR, 8'h00, 4'hE, d);
        rd_chk(`RSEC_CFG_ADDR, 32'h3F, "cfg lane off");
        wr(32'h0000_0100, 8'hFF);
        rd_chk(32'h0000_0100, 32'h0, "unmapped read");
        // Every clear-channel mode against every input pair
        for (int m = 0; m < 4; m++) begin
            wr(`RSEC_CFG_ADDR, {2'b00, m[1:0], 4'h0});
            for (int c = 0; c < 4; c++) begin
                @(posedge clk);
                rf_in <= rsec_rf_in_s'({c[1:0], 4'h0});
                @(posedge clk);
                #1;
                exp_flag = (m == 0) ? 1'b1 : (m == 1) ? c[1] :
                           (m == 2) ? !c[0] : (c[1] && !c[0]);
                chk(channel_clear_flag, exp_flag, "clear flag");
            end
        end
        @(posedge clk);
        rf_in <= rsec_rf_in_s'(6'h00);
        // Next state after a received packet, with clear check off
        for (int v = 0; v < 4; v++) begin
            wr(`RSEC_CFG_ADDR, {4'h0, v[1:0], 2'b00});
            pulse_cmd(3'h4);
            chk(radio_state, RSEC_ST_RX, "enter rx");
            // Status word: flag high in always mode, state receive
            rd_chk(`RSEC_STAT_ADDR, 32'h5, "status in rx");
            pulse_rf(6'h08);
            chk(radio_state, rx_next[v], "after rx");
            pulse_cmd(3'h1);
            chk(radio_state, RSEC_ST_IDLE, "go idle");
        end
        // Next state after a sent packet and preamble repeat
        for (int v = 0; v < 4; v++) begin
            wr(`RSEC_CFG_ADDR, {6'h00, v[1:0]});
            pulse_cmd(3'h2);
            chk(radio_state, RSEC_ST_TX, "enter tx");
            pulse_rf(6'h04);
            chk(radio_state, tx_next[v], "after tx");
            chk(preamble_restart, v == 2, "preamble restart");
            pulse_cmd(3'h1);
            chk(preamble_restart, 1'b0, "restart pulse width");
        end
        // Timeout halves per setting step, top setting disables it
        run_tmo(2'h0, 3'h0, 1'b0, 6'h00, n0);
        chk(radio_state, RSEC_ST_IDLE, "timeout exit");
        run_tmo(2'h0, 3'h1, 1'b0, 6'h00, n);
        chk(n0 - n, UNIT / 2, "timeout halved");
        run_tmo(2'h0, 3'h6, 1'b0, 6'h00, n);
        chk(n0 - n, UNIT - 1, "shortest timeout");
        // Wider resolution columns scale the same shortest setting
        run_tmo(2'h1, 3'h6, 1'b0, 6'h00, n);
        chk(n, (UNIT * `RSEC_MULT_RES1) / 64 + 2, "column one");
        run_tmo(2'h2, 3'h6, 1'b0, 6'h00, n);
        chk(n, (UNIT * `RSEC_MULT_RES2) / 64 + 2, "column two");
        run_tmo(2'h3, 3'h6, 1'b0, 6'h00, n);
        chk(n, (UNIT * `RSEC_MULT_RES3) / 64 + 2, "column three");
        run_tmo(2'h0, 3'h7, 1'b0, 6'h00, n);
        chk(n, WAIT_MAX, "timeout disabled");
        chk(radio_state, RSEC_ST_RX, "stays rx");
        pulse_cmd(3'h1);
        // Qualifiers keep receive alive at expiry
        run_tmo(2'h0, 3'h0, 1'b0, 6'h02, n);
        chk(radio_state, RSEC_ST_RX, "sync keeps rx");
        pulse_cmd(3'h1);
        run_tmo(2'h0, 3'h0, 1'b1, 6'h01, n);
        chk(radio_state, RSEC_ST_RX, "quality keeps rx");
        pulse_cmd(3'h1);
        run_tmo(2'h0, 3'h0, 1'b0, 6'h01, n);
        chk(radio_state, RSEC_ST_IDLE, "quality ignored");
        give_verdict();
    end

endmodule
